// ===== design/aslm_mapper.sv
/*
  aslm_mapper: samples eight channel codes, delays them through the conversion
  pipeline and serialises them onto sixteen lanes through per-lane selectors.
  Assumes: register port on clk_sys_in, lane logic on a free-running clk_lane_in,
  channel codes and sample clock pins asynchronous to both.
*/
// The strobed register port and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps

// How it works
// - six registers hold sixteen 4-bit lane selectors
// - low group even codes pick channels 1-4
// - low group odd codes give high half
// - selector top bit powers the lane down
// - high group even codes pick channels 8-5
// - high group odd codes give high half
// - one-lane default: only primary lanes carry data
// - two-lane default: both lanes carry channel k
// - all channels captured on one sample edge
// - words leave pipeline eleven sample edges later
// - one or two lanes per channel word
// - bit clock seven per one-lane 12/14-bit frame (five at 10 bits, fewer in two-lane), frame clock one per frame of lane clock cycles
// - resolution selectable 14, 12 or 10 bits
// - negative clock pin grounded means single-ended
// - channels stay within their own lane group
// - sixteen lanes, two groups of eight
module aslm_mapper (
  input  wire logic         clk_sys_in,
  input  wire logic         srst_in,
  input  wire logic         ce_in,
  input  wire logic [7:0]   reg_addr_in,
  input  wire logic [15:0]  reg_wdata_in,
  input  wire logic         reg_wr_in,
  input  wire logic         reg_rd_in,
  output logic      [15:0]  reg_rdata_out,
  input  wire logic         sample_clock_positive_in,
  input  wire logic         sample_clock_negative_in,
  input  wire logic [111:0] analog_source_channel_in,
  input  wire logic         clk_lane_in,
  output logic      [7:0]   primary_serial_lane_out,
  output logic      [7:0]   secondary_serial_lane_out,
  output logic      [7:0]   primary_serial_lane_pwr_out,
  output logic      [7:0]   secondary_serial_lane_pwr_out,
  output logic              bit_clock_out,
  output logic              frame_clock_out
);

  localparam int DW = aslm_pkg::NUM_CH * aslm_pkg::CODE_W;
  localparam int SW = aslm_pkg::NUM_LANE * aslm_pkg::SEL_W;

  // ****************************************
  // register file
  // ****************************************
  logic [aslm_pkg::MAP_W-1:0]  map_ff [aslm_pkg::NUM_MAP];
  logic [aslm_pkg::CTRL_W-1:0] ctrl_ff;
  logic [15:0]                 reg_rdata_ff;
  logic [15:0]                 nxt_rdata;
  logic                        in_map;
  logic [2:0]                  map_idx;
  logic [SW-1:0]               sel_vec;
  aslm_pkg::aslm_clk_t         det_state_ff;

  assign in_map  = (reg_addr_in >= aslm_pkg::ADDR_MAP_BASE) &&
                   (reg_addr_in <= aslm_pkg::ADDR_MAP_LAST);
  assign map_idx = 3'(reg_addr_in - aslm_pkg::ADDR_MAP_BASE);

  always_ff @(posedge clk_sys_in) begin
    if (srst_in) begin
      for (int i = 0; i < aslm_pkg::NUM_MAP; i++) begin
        map_ff[i] <= aslm_pkg::RST_MAP[i];
      end
      ctrl_ff <= aslm_pkg::RST_CTRL;
    end else if (ce_in && reg_wr_in) begin
      if (in_map) begin
        map_ff[map_idx] <= reg_wdata_in[aslm_pkg::MAP_W-1:0];
      end else if (reg_addr_in == aslm_pkg::ADDR_CTRL) begin
        ctrl_ff <= reg_wdata_in[aslm_pkg::CTRL_W-1:0];
      end
    end
  end

  always_comb begin
    nxt_rdata = '0;
    if (in_map) begin
      nxt_rdata = {4'h0, map_ff[map_idx]};
    end else if (reg_addr_in == aslm_pkg::ADDR_CTRL) begin
      nxt_rdata = {13'h0, ctrl_ff};
    end else if (reg_addr_in == aslm_pkg::ADDR_STAT) begin
      nxt_rdata[aslm_pkg::STAT_SE_BIT]   = (det_state_ff == aslm_pkg::DET_SE);
      nxt_rdata[aslm_pkg::STAT_DIFF_BIT] = (det_state_ff == aslm_pkg::DET_DIFF);
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (srst_in) begin
      reg_rdata_ff <= '0;
    end else if (ce_in) begin
      reg_rdata_ff <= reg_rd_in ? nxt_rdata : '0;
    end
  end

  assign reg_rdata_out = reg_rdata_ff;

  // sixteen selectors gathered from the six registers
  for (genvar l = 0; l < aslm_pkg::NUM_LANE; l++) begin : g_sel
    assign sel_vec[l*4 +: 4] = map_ff[aslm_pkg::LANE_REG[l]][aslm_pkg::LANE_POS[l]*4 +: 4];
  end

  // ****************************************
  // sample clock pins and type detection
  // ****************************************
  logic       pos_s1_ff;
  logic       pos_s2_ff;
  logic       neg_s1_ff;
  logic       neg_s2_ff;
  logic       lvl_d_ff;
  logic       clk_lvl;
  logic       smp_edge;
  logic [6:0] win_cnt_ff;

  always_ff @(posedge clk_sys_in) begin
    if (srst_in) begin
      pos_s1_ff <= 1'b0;
      pos_s2_ff <= 1'b0;
      neg_s1_ff <= 1'b0;
      neg_s2_ff <= 1'b0;
    end else if (ce_in) begin
      pos_s1_ff <= sample_clock_positive_in;
      pos_s2_ff <= pos_s1_ff;
      neg_s1_ff <= sample_clock_negative_in;
      neg_s2_ff <= neg_s1_ff;
    end
  end

  // any high level on the negative pin means differential; a quiet window means grounded
  always_ff @(posedge clk_sys_in) begin
    if (srst_in) begin
      det_state_ff <= aslm_pkg::DET_SE;
      win_cnt_ff   <= '0;
    end else if (ce_in) begin
      case (det_state_ff)
        aslm_pkg::DET_SE, aslm_pkg::DET_DIFF: begin
          if (neg_s2_ff) begin
            det_state_ff <= aslm_pkg::DET_DIFF;
            win_cnt_ff   <= '0;
          end else if (win_cnt_ff == 7'(aslm_pkg::CLK_DET_WIN_CYC - 1)) begin
            det_state_ff <= aslm_pkg::DET_SE;
            win_cnt_ff   <= '0;
          end else begin
            win_cnt_ff <= win_cnt_ff + 7'h1;
          end
        end
        default: begin
          det_state_ff <= aslm_pkg::DET_SE;
          win_cnt_ff   <= '0;
        end
      endcase
    end
  end

  assign clk_lvl  = (det_state_ff == aslm_pkg::DET_SE) ? pos_s2_ff : (pos_s2_ff & ~neg_s2_ff);
  assign smp_edge = clk_lvl & ~lvl_d_ff;

  always_ff @(posedge clk_sys_in) begin
    if (srst_in) begin
      lvl_d_ff <= 1'b0;
    end else if (ce_in) begin
      lvl_d_ff <= clk_lvl;
    end
  end

  // ****************************************
  // capture and conversion pipeline
  // ****************************************
  logic [DW-1:0] ain_s1_ff;
  logic [DW-1:0] ain_s2_ff;
  logic [DW-1:0] pipe_ff [aslm_pkg::PIPE_LAT];
  logic [3:0]    fill_cnt_ff;

  always_ff @(posedge clk_sys_in) begin
    if (srst_in) begin
      ain_s1_ff <= '0;
      ain_s2_ff <= '0;
    end else if (ce_in) begin
      ain_s1_ff <= analog_source_channel_in;
      ain_s2_ff <= ain_s1_ff;
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (srst_in) begin
      for (int i = 0; i < aslm_pkg::PIPE_LAT; i++) begin
        pipe_ff[i] <= '0;
      end
      fill_cnt_ff <= '0;
    end else if (ce_in && smp_edge) begin
      pipe_ff[0] <= ain_s2_ff;
      for (int i = 1; i < aslm_pkg::PIPE_LAT; i++) begin
        pipe_ff[i] <= pipe_ff[i-1];
      end
      if (fill_cnt_ff != 4'(aslm_pkg::PIPE_LAT)) begin
        fill_cnt_ff <= fill_cnt_ff + 4'h1;
      end
    end
  end

  // ****************************************
  // word handover to the lane domain
  // ****************************************
  logic [DW-1:0]               hold_dat_ff;
  logic [SW-1:0]               hold_sel_ff;
  logic [aslm_pkg::CTRL_W-1:0] hold_cfg_ff;
  logic                        req_ff;
  logic                        ack_s1_ff;
  logic                        ack_s2_ff;
  logic                        ack_ff;
  logic                        load_word;

  assign load_word = smp_edge && (fill_cnt_ff == 4'(aslm_pkg::PIPE_LAT)) &&
                     (req_ff == ack_s2_ff);

  always_ff @(posedge clk_sys_in) begin
    if (srst_in) begin
      hold_dat_ff <= '0;
      hold_sel_ff <= '0;
      hold_cfg_ff <= aslm_pkg::RST_CTRL;
      req_ff      <= 1'b0;
    end else if (ce_in && load_word) begin
      hold_dat_ff <= pipe_ff[aslm_pkg::PIPE_LAT-1];
      hold_sel_ff <= sel_vec;
      hold_cfg_ff <= ctrl_ff;
      req_ff      <= ~req_ff;
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (srst_in) begin
      ack_s1_ff <= 1'b0;
      ack_s2_ff <= 1'b0;
    end else if (ce_in) begin
      ack_s1_ff <= ack_ff;
      ack_s2_ff <= ack_s1_ff;
    end
  end

  // ****************************************
  // lane domain: reset, enable and request sync
  // ****************************************
  logic lrst_s1_ff;
  logic lrst_s2_ff;
  logic lce_s1_ff;
  logic lce_s2_ff;
  logic req_s1_ff;
  logic req_s2_ff;

  always_ff @(posedge clk_lane_in) begin
    lrst_s1_ff <= srst_in;
    lrst_s2_ff <= lrst_s1_ff;
  end

  always_ff @(posedge clk_lane_in) begin
    if (lrst_s2_ff) begin
      lce_s1_ff <= 1'b0;
      lce_s2_ff <= 1'b0;
      req_s1_ff <= 1'b0;
      req_s2_ff <= 1'b0;
    end else begin
      lce_s1_ff <= ce_in;
      lce_s2_ff <= lce_s1_ff;
      req_s1_ff <= req_ff;
      req_s2_ff <= req_s1_ff;
    end
  end

  // ****************************************
  // lane domain: frame timing and latch
  // ****************************************
  logic [DW-1:0] lat_dat_ff;
  logic [SW-1:0] lat_sel_ff;
  logic          lat_two_ff;
  logic [1:0]    lat_res_ff;
  logic [3:0]    frm_cnt_ff;
  logic [3:0]    flen;
  logic [3:0]    hlf;
  logic          frm_end;
  logic          frm_clk_ff;
  logic          bclk_ff;

  assign flen    = ((lat_res_ff == aslm_pkg::RES_10) ? aslm_pkg::FRAME_NARROW
                                                     : aslm_pkg::FRAME_WIDE) >> lat_two_ff;
  assign hlf     = 4'((flen + 4'h1) >> 1);
  assign frm_end = (frm_cnt_ff == 4'(flen - 4'h1));

  always_ff @(posedge clk_lane_in) begin
    if (lrst_s2_ff) begin
      frm_cnt_ff <= '0;
      lat_dat_ff <= '0;
      lat_sel_ff <= '1;
      lat_two_ff <= 1'b0;
      lat_res_ff <= aslm_pkg::RES_12;
      ack_ff     <= 1'b0;
    end else if (lce_s2_ff) begin
      if (frm_end) begin
        frm_cnt_ff <= '0;
        if (req_s2_ff != ack_ff) begin
          lat_dat_ff <= hold_dat_ff;
          lat_sel_ff <= hold_sel_ff;
          lat_two_ff <= hold_cfg_ff[aslm_pkg::CTRL_TWO_LANE_BIT];
          lat_res_ff <= hold_cfg_ff[aslm_pkg::CTRL_RES_LSB +: 2];
          ack_ff     <= ~ack_ff;
        end
      end else begin
        frm_cnt_ff <= frm_cnt_ff + 4'h1;
      end
    end
  end

  always_ff @(posedge clk_lane_in) begin
    if (lrst_s2_ff) begin
      frm_clk_ff <= 1'b0;
      bclk_ff    <= 1'b0;
    end else if (lce_s2_ff) begin
      frm_clk_ff <= (frm_cnt_ff < hlf);
      bclk_ff    <= ~frm_cnt_ff[0];
    end
  end

  assign frame_clock_out = frm_clk_ff;
  assign bit_clock_out   = bclk_ff;

  // ****************************************
  // lane domain: per-lane selector and serialiser
  // ****************************************
  function automatic logic [13:0] ser_word(input logic [13:0] code, input logic [1:0] res);
    logic [13:0] w;
    case (res)
      aslm_pkg::RES_14: w = code;
      aslm_pkg::RES_10: w = {4'h0, code[13:4]};
      default:          w = {code[13:2], 2'b00};
    endcase
    return w;
  endfunction : ser_word

  logic lane_ff     [aslm_pkg::NUM_LANE];
  logic lane_pwr_ff [aslm_pkg::NUM_LANE];

  for (genvar l = 0; l < aslm_pkg::NUM_LANE; l++) begin : g_lane
    logic [3:0]  sel;
    logic [2:0]  src_ch;
    logic [3:0]  bit_idx;
    logic [13:0] sw;
    logic        live;

    assign sel = lat_sel_ff[l*4 +: 4];
    if (l < 8) begin : g_lo
      assign src_ch = {1'b0, sel[2:1]};
    end else begin : g_hi
      assign src_ch = 3'h7 - {1'b0, sel[2:1]};
    end
    assign sw      = ser_word(lat_dat_ff[src_ch*aslm_pkg::CODE_W +: aslm_pkg::CODE_W],
                              lat_res_ff);
    assign bit_idx = 4'(frm_cnt_ff + (sel[0] ? flen : 4'h0));
    assign live    = ~sel[3] & (lat_two_ff | ~sel[0]);

    always_ff @(posedge clk_lane_in) begin
      if (lrst_s2_ff) begin
        lane_ff[l]     <= 1'b0;
        lane_pwr_ff[l] <= 1'b0;
      end else if (lce_s2_ff) begin
        lane_ff[l]     <= live & sw[bit_idx];
        lane_pwr_ff[l] <= ~sel[3];
      end
    end

    property p_pd_quiet;
      @(posedge clk_lane_in) disable iff (srst_in || lrst_s2_ff)
        !lane_pwr_ff[l] |-> !lane_ff[l];
    endproperty
    a_pd_quiet : assert property (p_pd_quiet)
      else $error("powered-down lane carries data");

    property p_group;
      @(posedge clk_lane_in) disable iff (srst_in || lrst_s2_ff)
        src_ch[2] == (l >= 8);
    endproperty
    a_group : assert property (p_group)
      else $error("lane sourced from the other group");

    property p_one_lane_odd;
      @(posedge clk_lane_in) disable iff (srst_in || lrst_s2_ff)
        (lce_s2_ff && !lat_two_ff && sel[0]) |=> !lane_ff[l];
    endproperty
    a_one_lane_odd : assert property (p_one_lane_odd)
      else $error("high-half code active in one-lane mode");
  end

  for (genvar n = 0; n < 8; n++) begin : g_out
    assign primary_serial_lane_out[n]       = lane_ff[2*n];
    assign secondary_serial_lane_out[n]     = lane_ff[2*n+1];
    assign primary_serial_lane_pwr_out[n]   = lane_pwr_ff[2*n];
    assign secondary_serial_lane_pwr_out[n] = lane_pwr_ff[2*n+1];
  end

  // ****************************************
  // checks
  // ****************************************
  property p_map_write;
    @(posedge clk_sys_in) disable iff (srst_in)
      (ce_in && reg_wr_in && reg_addr_in == aslm_pkg::ADDR_MAP_BASE)
        |=> map_ff[0] == $past(reg_wdata_in[11:0]);
  endproperty
  a_map_write : assert property (p_map_write) else $error("selector write lost");

  property p_sim_sample;
    @(posedge clk_sys_in) disable iff (srst_in)
      (ce_in && smp_edge) |=> pipe_ff[0] == $past(ain_s2_ff);
  endproperty
  a_sim_sample : assert property (p_sim_sample)
    else $error("channels not captured together");

  property p_latency;
    @(posedge clk_sys_in) disable iff (srst_in)
      (fill_cnt_ff < 4'(aslm_pkg::PIPE_LAT)) |=> $stable(req_ff);
  endproperty
  a_latency : assert property (p_latency) else $error("word left pipeline too early");

  property p_clk_det;
    @(posedge clk_sys_in) disable iff (srst_in)
      (ce_in && neg_s2_ff) |=> det_state_ff == aslm_pkg::DET_DIFF;
  endproperty
  a_clk_det : assert property (p_clk_det)
    else $error("driven negative clock pin not seen as differential");

  property p_cfg_frame;
    @(posedge clk_lane_in) disable iff (srst_in || lrst_s2_ff)
      !frm_end |=> ($stable(lat_sel_ff) && $stable(ack_ff));
  endproperty
  a_cfg_frame : assert property (p_cfg_frame) else $error("selector changed mid-frame");

  property p_frame_len;
    @(posedge clk_lane_in) disable iff (srst_in || lrst_s2_ff)
      frm_cnt_ff < flen;
  endproperty
  a_frame_len : assert property (p_frame_len)
    else $error("frame counter past frame length");

  property p_clocks;
    @(posedge clk_lane_in) disable iff (srst_in || lrst_s2_ff)
      (lce_s2_ff && frm_cnt_ff == 4'h0) |=> (frm_clk_ff && bclk_ff);
  endproperty
  a_clocks : assert property (p_clocks) else $error("frame and bit clocks misaligned");

  property p_two_lane;
    @(posedge clk_lane_in) disable iff (srst_in || lrst_s2_ff)
      (frm_end && req_s2_ff != ack_ff && lce_s2_ff) |=> lat_two_ff == $past(hold_cfg_ff[0]);
  endproperty
  a_two_lane : assert property (p_two_lane)
    else $error("lane mode not taken at frame end");

endmodule : aslm_mapper

// ===== design/aslm_pkg.sv
/*
  aslm_pkg: constants and types shared by the serial lane channel mapper.
  Assumes: one 16-bit register port, sixteen output lanes in two groups of eight.
*/
package aslm_pkg;

  // ****************************************
  // sizes
  // ****************************************
  localparam int NUM_CH   = 8;
  localparam int CODE_W   = 14;
  localparam int NUM_LANE = 16;
  localparam int SEL_W    = 4;
  localparam int NUM_MAP  = 6;
  localparam int MAP_W    = 12;
  localparam int REG_W    = 16;
  localparam int ADDR_W   = 8;
  localparam int CTRL_W   = 3;
  localparam int PIPE_LAT = 11;

  // ****************************************
  // register map
  // ****************************************
  localparam logic [7:0] ADDR_MAP_BASE = 8'h50;
  localparam logic [7:0] ADDR_MAP_LAST = 8'h55;
  localparam logic [7:0] ADDR_CTRL     = 8'h56;
  localparam logic [7:0] ADDR_STAT     = 8'h57;

  localparam int CTRL_TWO_LANE_BIT = 0;
  localparam int CTRL_RES_LSB      = 1;
  localparam int STAT_SE_BIT       = 0;
  localparam int STAT_DIFF_BIT     = 1;

  localparam logic [2:0]  RST_CTRL = 3'h0;
  localparam logic [11:0] RST_MAP [6] = '{12'h210, 12'h543, 12'h076,
                                          12'h567, 12'h234, 12'h001};

  // lane l = 2*pair + (0 primary, 1 secondary): register index and field slot
  localparam int LANE_REG [16] = '{0, 0, 0, 1, 1, 1, 2, 2, 3, 3, 4, 3, 4, 4, 5, 5};
  localparam int LANE_POS [16] = '{0, 1, 2, 0, 1, 2, 0, 1, 1, 0, 0, 2, 2, 1, 1, 0};

  // ****************************************
  // timing
  // ****************************************
  localparam logic [3:0] FRAME_WIDE      = 4'hE;
  localparam logic [3:0] FRAME_NARROW    = 4'hA;
  localparam int         CLK_DET_WIN_CYC = 64;

  // ****************************************
  // types
  // ****************************************
  typedef enum logic [1:0] {
    RES_12 = 2'b00,
    RES_14 = 2'b01,
    RES_10 = 2'b11
  } aslm_res_t;

  typedef enum logic {
    DET_SE   = 1'b0,
    DET_DIFF = 1'b1
  } aslm_clk_t;

endpackage : aslm_pkg

// ===== test/aslm_rx_model.sv
/*
  aslm_rx_model: receiver that captures the sixteen serial lanes.
  Assumes: frame clock rises on the first bit of each frame, bits arrive LSB first.
*/
`timescale 1ns/1ps
module aslm_rx_model (
  input  wire logic        clk_lane_in,
  input  wire logic [7:0]  pri_in,
  input  wire logic [7:0]  sec_in,
  input  wire logic        frame_clock_in,
  input  wire logic        bit_clock_in,
  output logic      [13:0] rx_pri_out [8],
  output logic      [13:0] rx_sec_out [8],
  output logic      [4:0]  rx_len_out,
  output logic      [3:0]  rx_bclk_out
);
  // ****************************************
  // capture on the falling lane edge
  // ****************************************
  logic [13:0] acc_p [8];
  logic [13:0] acc_s [8];
  logic [4:0]  idx   = 5'h00;
  logic [3:0]  rises = 4'h0;
  logic        fc_q  = 1'b1;
  logic        bc_q  = 1'b1;

  always @(negedge clk_lane_in) begin
    fc_q <= frame_clock_in;
    bc_q <= bit_clock_in;
    if (frame_clock_in && !fc_q) begin
      rx_pri_out  <= acc_p;
      rx_sec_out  <= acc_s;
      rx_len_out  <= idx;
      rx_bclk_out <= rises;
      idx         <= 5'h01;
      rises       <= 4'(bit_clock_in && !bc_q);
      for (int i = 0; i < 8; i++) begin
        acc_p[i] <= 14'(pri_in[i]);
        acc_s[i] <= 14'(sec_in[i]);
      end
    end else begin
      idx   <= idx + 5'h01;
      rises <= rises + 4'(bit_clock_in && !bc_q);
      for (int i = 0; i < 8; i++) begin
        if (idx < 5'h0E) begin
          acc_p[i][idx] <= pri_in[i];
          acc_s[i][idx] <= sec_in[i];
        end
      end
    end
  end
endmodule : aslm_rx_model

// ===== test/test_adc_serial_lane_channel_mapper.sv
/*
  test_adc_serial_lane_channel_mapper: self-checking bench for the lane mapper.
  Assumes: aslm_pkg, aslm_mapper and aslm_rx_model compiled before it.
*/
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin \
  samples_checked++; \
  if ((got) !== (ex)) begin \
    error_cnt++; \
    $display("Error %s expected %h seen %h", nm, ex, got); \
  end \
end
module test_adc_serial_lane_channel_mapper;
  // ****************************************
  // signals and clocks
  // ****************************************
  logic         clk_sys  = 1'b0;
  logic         clk_lane = 1'b0;
  logic         srst     = 1'b1;
  logic [7:0]   addr     = 8'h00;
  logic [15:0]  wdata    = 16'h0000;
  logic         wr       = 1'b0;
  logic         rd       = 1'b0;
  logic [15:0]  rdata;
  logic         smp_p    = 1'b0;
  logic         smp_n    = 1'b0;
  logic         diff_clk = 1'b0;
  logic [111:0] codes    = '0;
  logic [7:0]   pri;
  logic [7:0]   sec;
  logic [7:0]   pri_pwr;
  logic [7:0]   sec_pwr;
  logic         bclk;
  logic         fclk;
  logic [13:0]  rx_pri [8];
  logic [13:0]  rx_sec [8];
  logic [4:0]   rx_len;
  logic [3:0]   rx_bclk;
  int           salt     = 0;
  int           error_cnt = 0;
  int           samples_checked = 0;

  initial begin
    forever #12.5 clk_sys = ~clk_sys;
  end
  initial begin
    #37;
    forever #80 clk_lane = ~clk_lane;
  end
  initial begin
    forever begin
      repeat (48) @(posedge clk_sys);
      smp_p <= ~smp_p;
      smp_n <= diff_clk & smp_p;
    end
  end

  aslm_mapper u_aslm_mapper (
    .clk_sys_in(clk_sys), .srst_in(srst), .ce_in(1'b1),
    .reg_addr_in(addr), .reg_wdata_in(wdata), .reg_wr_in(wr), .reg_rd_in(rd),
    .reg_rdata_out(rdata), .sample_clock_positive_in(smp_p),
    .sample_clock_negative_in(smp_n), .analog_source_channel_in(codes),
    .clk_lane_in(clk_lane), .primary_serial_lane_out(pri), .secondary_serial_lane_out(sec),
    .primary_serial_lane_pwr_out(pri_pwr), .secondary_serial_lane_pwr_out(sec_pwr),
    .bit_clock_out(bclk), .frame_clock_out(fclk));

  aslm_rx_model u_aslm_rx_model (
    .clk_lane_in(clk_lane), .pri_in(pri), .sec_in(sec), .frame_clock_in(fclk),
    .bit_clock_in(bclk), .rx_pri_out(rx_pri), .rx_sec_out(rx_sec),
    .rx_len_out(rx_len), .rx_bclk_out(rx_bclk));

  // ****************************************
  // helpers
  // ****************************************
  function automatic logic [13:0] code_of(input int k, input int s);
    return 14'(((k + 1) * 32'h0000_0A53) ^ (s * 32'h0000_1C3D));
  endfunction : code_of

  function automatic logic [13:0] lane_exp(input logic [13:0] c, input logic [1:0] res,
                                           input bit two, input bit hi);
    logic [13:0] w;
    int          h;
    w = (res == aslm_pkg::RES_14) ? c :
        (res == aslm_pkg::RES_10) ? 14'(c[13:4]) : {c[13:2], 2'b00};
    h = (res == aslm_pkg::RES_10) ? 5 : 7;
    if (!two) return hi ? 14'h0000 : w;
    return hi ? (w >> h) : (w & 14'((1 << h) - 1));
  endfunction : lane_exp

  task automatic reg_wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk_sys);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk_sys);
    wr    <= 1'b0;
  endtask : reg_wr

  task automatic reg_chk(input logic [7:0] a, input logic [15:0] ex);
    @(posedge clk_sys);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk_sys);
    rd   <= 1'b0;
    #1;
    `CHK("reg_rdata_out", ex, rdata)
  endtask : reg_chk

  task automatic set_codes(input int s);
    repeat (10) @(posedge clk_sys);
    salt = s;
    for (int k = 0; k < 8; k++) begin
      codes[14*k +: 14] <= code_of(k, s);
    end
  endtask : set_codes

  task automatic chk_pairs(input bit two, input logic [1:0] res);
    logic [4:0] f;
    f = (res == aslm_pkg::RES_10) ? 5'h0A : 5'h0E;
    for (int k = 0; k < 8; k++) begin
      `CHK("rx_pri", lane_exp(code_of(k, salt), res, two, 1'b0), rx_pri[k])
      `CHK("rx_sec", lane_exp(code_of(k, salt), res, two, 1'b1), rx_sec[k])
    end
    `CHK("rx_len", two ? (f >> 1) : f, rx_len)
  endtask : chk_pairs

  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_reset();
    repeat (80) @(posedge clk_sys);
    for (int i = 0; i < 6; i++) begin
      reg_chk(8'(aslm_pkg::ADDR_MAP_BASE + i), 16'(aslm_pkg::RST_MAP[i]));
    end
    reg_wr(8'h58, 16'hFFFF);
    reg_wr(8'h57, 16'h0002);
    reg_chk(8'h58, 16'h0000);
    reg_chk(8'h56, 16'h0000);
    reg_chk(8'h57, 16'h0001);
    $display("t_reset done");
  endtask : t_reset

  task automatic t_default_one();
    set_codes(1);
    repeat (16) @(posedge smp_p);
    chk_pairs(1'b0, aslm_pkg::RES_12);
    `CHK("rx_bclk", 4'h7, rx_bclk)
    `CHK("pri_pwr", 8'hFF, pri_pwr)
    `CHK("sec_pwr", 8'hFF, sec_pwr)
    $display("t_default_one done");
  endtask : t_default_one

  task automatic t_clk_type();
    @(posedge clk_sys);
    diff_clk <= 1'b1;
    repeat (3) @(posedge smp_p);
    reg_chk(aslm_pkg::ADDR_STAT, 16'h0002);
    @(posedge clk_sys);
    diff_clk <= 1'b0;
    repeat (2) @(posedge smp_p);
    reg_chk(aslm_pkg::ADDR_STAT, 16'h0001);
    $display("t_clk_type done");
  endtask : t_clk_type

  task automatic t_latency();
    @(posedge smp_p);
    set_codes(2);
    repeat (11) @(posedge smp_p);
    repeat (40) @(posedge clk_sys);
    `CHK("old word", lane_exp(code_of(0, 1), aslm_pkg::RES_12, 1'b0, 1'b0), rx_pri[0])
    @(posedge smp_p);
    repeat (320) @(posedge clk_sys);
    chk_pairs(1'b0, aslm_pkg::RES_12);
    $display("t_latency done");
  endtask : t_latency

  task automatic t_res();
    aslm_pkg::aslm_res_t rl [3];
    rl = '{aslm_pkg::RES_14, aslm_pkg::RES_10, aslm_pkg::RES_12};
    for (int i = 0; i < 3; i++) begin
      reg_wr(8'h56, {13'h0000, rl[i], 1'b0});
      repeat (5) @(posedge smp_p);
      chk_pairs(1'b0, rl[i]);
    end
    $display("t_res done");
  endtask : t_res

  task automatic t_two_lane();
    reg_wr(8'h56, 16'h0001);
    repeat (5) @(posedge smp_p);
    chk_pairs(1'b1, aslm_pkg::RES_12);
    $display("t_two_lane done");
  endtask : t_two_lane

  task automatic t_codes();
    for (int c = 0; c < 8; c++) begin
      reg_wr(8'h50, 16'h0210 | 16'(c));
      reg_wr(8'h55, 16'h0001 | 16'(c << 4));
      repeat (5) @(posedge smp_p);
      `CHK("lane 1A", lane_exp(code_of(c / 2, salt), 2'b00, 1'b1, 1'(c)), rx_pri[0])
      `CHK("lane 8A", lane_exp(code_of(7 - c / 2, salt), 2'b00, 1'b1, 1'(c)), rx_pri[7])
      `CHK("lane 2A", lane_exp(code_of(1, salt), 2'b00, 1'b1, 1'b0), rx_pri[1])
    end
    $display("t_codes done");
  endtask : t_codes

  task automatic t_power();
    reg_wr(8'h50, 16'h0218);
    reg_wr(8'h55, 16'h00F1);
    repeat (5) @(posedge smp_p);
    `CHK("pri_pwr", 8'h7E, pri_pwr)
    `CHK("lane 1A off", 14'h0000, rx_pri[0])
    `CHK("lane 8A off", 14'h0000, rx_pri[7])
    `CHK("sec_pwr", 8'hFF, sec_pwr)
    reg_chk(8'h55, 16'h00F1);
    $display("t_power done");
  endtask : t_power

  // ****************************************
  // run control
  // ****************************************
  task automatic end_sim();
    $display("checks %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : end_sim

  initial begin
    repeat (8) @(posedge clk_lane);
    @(posedge clk_sys);
    srst <= 1'b0;
    t_reset();
    t_default_one();
    t_clk_type();
    t_latency();
    t_res();
    t_two_lane();
    t_codes();
    t_power();
    end_sim();
  end

  initial begin
    repeat (20000) @(posedge clk_sys);
    error_cnt++;
    end_sim();
  end
endmodule : test_adc_serial_lane_channel_mapper
